// ---- include/abx_map.svh ----
/*
 Offsets, field positions, reset values and encodings of the
 instruction slice and its register slave.
 Assumes inclusion by bare name from the design and verification files.
*/
// Behaviour
// - Upper six bits 000101 decode as AND-with-file; bit9 dest, bit8 access, low byte address.
// - AND W with the file register; dest 0 writes W, dest 1 writes the file.
// - Access bit 0 resolves the address in the access bank, ignoring the bank select.
// - Access bit 1 forms the data address from bank select and the 8-bit address.
// - AND-with-file updates only negative and zero flags from its result.
// - Bit clear and the three branches leave every flag unchanged.
// - Upper byte 11100010 decodes as branch on carry set, low byte signed offset.
// - Branch on carry set is taken only when carry is 1.
// - Taken branch loads counter plus twice the sign-extended offset, range -128 to 127.
// - Taken branch takes two cycles, the second flushing the prefetch; untaken takes one.
// - Upper nibble 1001 decodes as bit clear; bits 11..9 bit number, clears only it.
// - Upper byte 11100110 is branch on negative, taken only when negative is 1.
// - Upper byte 11100011 is branch on carry clear, taken only when carry is 0.
// - Branch base counter already points past the branch word.
`ifndef ABX_MAP_SVH
`define ABX_MAP_SVH

// ----------------------------
// Widths
// ----------------------------
`define ABX_AXI_AW 8
`define ABX_PROG_W 21
`define ABX_DATA_AW 12
`define ABX_PROG_STEP 21'h000002

// ----------------------------
// Register offsets
// ----------------------------
`define ABX_ADR_CTRL 8'h00
`define ABX_ADR_WREG 8'h04
`define ABX_ADR_FLAGS 8'h08
`define ABX_ADR_BANK 8'h0C
`define ABX_ADR_PROG 8'h10
`define ABX_ADR_STAT 8'h14

// ----------------------------
// Fields and reset values
// ----------------------------
`define ABX_CTRL_RUN 0
`define ABX_FLG_C 0
`define ABX_FLG_DC 1
`define ABX_FLG_Z 2
`define ABX_FLG_OV 3
`define ABX_FLG_N 4
`define ABX_RST_WREG 8'h00
`define ABX_RST_FLAGS 5'h00
`define ABX_RST_BANK 4'h0
`define ABX_RST_PROG 21'h000000
`define ABX_RESP_OKAY 2'h0
`define ABX_RESP_SLVERR 2'h2

// ----------------------------
// Access bank split and encodings
// ----------------------------
`define ABX_ACC_SPLIT 8'h80
`define ABX_ACC_HI_BANK 4'hF
`define ABX_ACC_LO_BANK 4'h0
`define ABX_OPC_AND_WORK_FILE 6'h05
`define ABX_OPC_CLR_FILE_BIT 4'h9
`define ABX_OPC_BR_CARRY_SET 8'hE2
`define ABX_OPC_BR_NEG_SET 8'hE6
`define ABX_OPC_BR_CARRY_CLR 8'hE3

`endif

// ---- include/abx_pkg.sv ----
/*
 Types shared by the instruction slice: operations and quarter phases.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package abx_pkg;

   // Decoded operation
   typedef enum logic [2:0] {
      OP_NONE = 3'h0,
      OP_AND_WORK_FILE = 3'h1,
      OP_CLR_FILE_BIT = 3'h2,
      OP_BR_CARRY_SET = 3'h3,
      OP_BR_NEG_SET = 3'h4,
      OP_BR_CARRY_CLR = 3'h5
   } abx_op_e;

   // Quarter phases, Gray ordered
   typedef enum logic [1:0] {
      PH_Q1 = 2'h0,
      PH_Q2 = 2'h1,
      PH_Q3 = 2'h3,
      PH_Q4 = 2'h2
   } abx_phase_e;

endpackage

// ---- include/abx_dec_if.sv ----
/*
 Carrier between the core and its instruction decoder.
 Assumes the core drives the word and the decoder the fields.
*/
interface abx_dec_if;
   import abx_pkg::*;

   logic [15:0] word;
   abx_op_e op;
   logic [7:0] fadr;
   logic to_file;
   logic use_bank;
   logic [2:0] bitn;
   logic [7:0] offs;

   modport dec (input word, output op, fadr, to_file, use_bank, bitn, offs);
   modport core (output word, input op, fadr, to_file, use_bank, bitn, offs);
endinterface

// ---- hdl/abx_qphase.sv ----
/*
 Quarter-phase sequencer: one phase per enabled clock.
 Assumes en comes from logic on the same clock.
*/
module abx_qphase
   import abx_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic en,
   output abx_phase_e phase
);

   abx_phase_e phase_q;

   // ----------------------------
   // Phase advance
   // ----------------------------
   // Walks Q1..Q4 while enabled, holds otherwise
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_q <= PH_Q1;
      end else if (en) begin
         case (phase_q)
            PH_Q1: phase_q <= PH_Q2;
            PH_Q2: phase_q <= PH_Q3;
            PH_Q3: phase_q <= PH_Q4;
            PH_Q4: phase_q <= PH_Q1;
            default: phase_q <= PH_Q1;
         endcase
      end
   end

   assign phase = phase_q;

endmodule // abx_qphase

// ---- hdl/abx_decode.sv ----
/*
 Instruction decoder for AND-with-file, bit clear and relative branches.
 Assumes a 16-bit instruction word stable through the cycle.
*/
`include "abx_map.svh"

module abx_decode
   import abx_pkg::*;
(
   abx_dec_if.dec dif
);

   // ----------------------------
   // Field split and opcode match
   // ----------------------------
   // Unknown words decode as no operation
   always_comb begin
      dif.fadr = dif.word[7:0];
      dif.to_file = dif.word[9];
      dif.use_bank = dif.word[8];
      dif.bitn = dif.word[11:9];
      dif.offs = dif.word[7:0];
      dif.op = OP_NONE;
      if (dif.word[15:10] == `ABX_OPC_AND_WORK_FILE) begin
         dif.op = OP_AND_WORK_FILE;
      end else if (dif.word[15:12] == `ABX_OPC_CLR_FILE_BIT) begin
         dif.op = OP_CLR_FILE_BIT;
      end else begin
         case (dif.word[15:8])
            `ABX_OPC_BR_CARRY_SET: dif.op = OP_BR_CARRY_SET;
            `ABX_OPC_BR_NEG_SET: dif.op = OP_BR_NEG_SET;
            `ABX_OPC_BR_CARRY_CLR: dif.op = OP_BR_CARRY_CLR;
            default: dif.op = OP_NONE;
         endcase
      end
   end

endmodule // abx_decode

// ---- hdl/abx_core.sv ----
/*
 Instruction slice: fetch, quarter-phase sequencing and execution of
 AND-with-file, bit clear and three relative branches, with an
 AXI4-Lite register slave for run control and architectural state.
 Assumes program and data memories on CLOCK with combinational read.
*/
`include "abx_map.svh"

module abx_core
   import abx_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic [`ABX_AXI_AW-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [`ABX_AXI_AW-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   output logic [`ABX_PROG_W-1:0] PROG_ADDR,
   input wire logic [15:0] PROG_DATA,
   output logic [`ABX_DATA_AW-1:0] DATA_ADDR,
   output logic [7:0] DATA_WDATA,
   output logic DATA_WE,
   input wire logic [7:0] DATA_RDATA
);

   // ----------------------------
   // Declarations
   // ----------------------------
   logic awready_q;
   logic wready_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic arready_q;
   logic rvalid_q;
   logic [1:0] rresp_q;
   logic [31:0] rdata_q;
   logic aw_held_q;
   logic w_held_q;
   logic [`ABX_AXI_AW-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic wr_fire;
   logic wr_map;
   logic run_q;
   logic [7:0] w_q;
   logic [4:0] flg_q;
   logic [3:0] bank_q;
   logic [`ABX_PROG_W-1:0] pc_q;
   logic [15:0] ir_q;
   logic flush_q;
   logic taken_q;
   logic [`ABX_DATA_AW-1:0] dm_addr_q;
   logic [7:0] opnd_q;
   logic [7:0] res_q;
   logic dm_we_q;
   logic res_w_q;
   logic res_nz_q;
   logic take_q;
   logic [7:0] x_res;
   logic x_file;
   logic x_w;
   logic x_nz;
   logic x_take;
   logic [`ABX_PROG_W-1:0] br_tgt;
   logic q1;
   logic q2;
   logic q3;
   logic q4;
   abx_phase_e phase;

   abx_dec_if dif ();

   // ----------------------------
   // Submodules
   // ----------------------------
   abx_qphase u_phase (
      .clk(CLOCK),
      .rst_n(RST_N),
      .en(run_q),
      .phase(phase)
   );

   abx_decode u_decode (
      .dif(dif)
   );

   assign dif.word = ir_q;

   // Phase strobes, only while running
   assign q1 = run_q && (phase == PH_Q1);
   assign q2 = run_q && (phase == PH_Q2);
   assign q3 = run_q && (phase == PH_Q3);
   assign q4 = run_q && (phase == PH_Q4);

   // ----------------------------
   // AXI write channel
   // ----------------------------
   assign wr_fire = aw_held_q && w_held_q && !bvalid_q;

   // Decode of writable offsets
   always_comb begin
      case (aw_addr_q)
         `ABX_ADR_CTRL, `ABX_ADR_WREG, `ABX_ADR_FLAGS: wr_map = 1'b1;
         `ABX_ADR_BANK, `ABX_ADR_PROG, `ABX_ADR_STAT: wr_map = 1'b1;
         default: wr_map = 1'b0;
      endcase
   end

   // Address and data taken in either order, answer after both
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= `ABX_RESP_OKAY;
      end else begin
         if (S_AXI_AWVALID && awready_q) begin
            aw_addr_q <= S_AXI_AWADDR;
            aw_held_q <= 1'b1;
            awready_q <= 1'b0;
         end
         if (S_AXI_WVALID && wready_q) begin
            w_data_q <= S_AXI_WDATA;
            w_strb_q <= S_AXI_WSTRB;
            w_held_q <= 1'b1;
            wready_q <= 1'b0;
         end
         if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_map ? `ABX_RESP_OKAY : `ABX_RESP_SLVERR;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
         end
         if (bvalid_q && S_AXI_BREADY) begin
            bvalid_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
         end
      end
   end

   // ----------------------------
   // AXI read channel
   // ----------------------------
   // One read at a time, data one cycle after the address
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rresp_q <= `ABX_RESP_OKAY;
         rdata_q <= 32'h00000000;
      end else if (S_AXI_ARVALID && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rresp_q <= `ABX_RESP_OKAY;
         case (S_AXI_ARADDR)
            `ABX_ADR_CTRL: rdata_q <= {31'h00000000, run_q};
            `ABX_ADR_WREG: rdata_q <= {24'h000000, w_q};
            `ABX_ADR_FLAGS: rdata_q <= {27'h0000000, flg_q};
            `ABX_ADR_BANK: rdata_q <= {28'h0000000, bank_q};
            `ABX_ADR_PROG: rdata_q <= {11'h000, pc_q};
            `ABX_ADR_STAT: rdata_q <= {27'h0000000, taken_q, flush_q, phase, run_q};
            default: begin
               rdata_q <= 32'h00000000;
               rresp_q <= `ABX_RESP_SLVERR;
            end
         endcase
      end else if (rvalid_q && S_AXI_RREADY) begin
         rvalid_q <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   // ----------------------------
   // Control and bank select
   // ----------------------------
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         run_q <= 1'b0;
         bank_q <= `ABX_RST_BANK;
      end else if (wr_fire && w_strb_q[0]) begin
         if (aw_addr_q == `ABX_ADR_CTRL) begin
            run_q <= w_data_q[`ABX_CTRL_RUN];
         end
         if (aw_addr_q == `ABX_ADR_BANK) begin
            bank_q <= w_data_q[3:0];
         end
      end
   end

   // ----------------------------
   // Execute: compute step
   // ----------------------------
   // Result, destination and branch decision; flushed cycle does nothing
   always_comb begin
      x_res = 8'h00;
      x_file = 1'b0;
      x_w = 1'b0;
      x_nz = 1'b0;
      x_take = 1'b0;
      if (!flush_q) begin
         case (dif.op)
            OP_AND_WORK_FILE: begin
               x_res = w_q & opnd_q;
               x_file = dif.to_file;
               x_w = !dif.to_file;
               x_nz = 1'b1;
            end
            OP_CLR_FILE_BIT: begin
               x_res = opnd_q & ~(8'h01 << dif.bitn);
               x_file = 1'b1;
            end
            OP_BR_CARRY_SET: x_take = flg_q[`ABX_FLG_C];
            OP_BR_NEG_SET: x_take = flg_q[`ABX_FLG_N];
            OP_BR_CARRY_CLR: x_take = !flg_q[`ABX_FLG_C];
            default: x_take = 1'b0;
         endcase
      end
   end

   // Target from the already advanced counter
   assign br_tgt = pc_q + {{(`ABX_PROG_W-9){dif.offs[7]}}, dif.offs, 1'b0};

   // ----------------------------
   // Execute: quarter-phase pipeline
   // ----------------------------
   // Q1 address, Q2 read, Q3 compute, write strobe during Q4
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         dm_addr_q <= 12'h000;
         opnd_q <= 8'h00;
         res_q <= 8'h00;
         res_w_q <= 1'b0;
         res_nz_q <= 1'b0;
         take_q <= 1'b0;
         dm_we_q <= 1'b0;
      end else begin
         dm_we_q <= q3 && x_file;
         if (q1) begin
            if (dif.use_bank) begin
               dm_addr_q <= {bank_q, dif.fadr};
            end else if (dif.fadr >= `ABX_ACC_SPLIT) begin
               dm_addr_q <= {`ABX_ACC_HI_BANK, dif.fadr};
            end else begin
               dm_addr_q <= {`ABX_ACC_LO_BANK, dif.fadr};
            end
         end
         if (q2) begin
            opnd_q <= DATA_RDATA;
         end
         if (q3) begin
            res_q <= x_res;
            res_w_q <= x_w;
            res_nz_q <= x_nz;
            take_q <= x_take;
         end
      end
   end

   // ----------------------------
   // Working register and flags
   // ----------------------------
   // Core write in Q4 wins over a software write
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         w_q <= `ABX_RST_WREG;
         flg_q <= `ABX_RST_FLAGS;
      end else begin
         if (wr_fire && w_strb_q[0] && aw_addr_q == `ABX_ADR_WREG) begin
            w_q <= w_data_q[7:0];
         end
         if (wr_fire && w_strb_q[0] && aw_addr_q == `ABX_ADR_FLAGS) begin
            flg_q <= w_data_q[4:0];
         end
         if (q4 && res_w_q) begin
            w_q <= res_q;
         end
         if (q4 && res_nz_q) begin
            flg_q[`ABX_FLG_N] <= res_q[7];
            flg_q[`ABX_FLG_Z] <= (res_q == 8'h00);
         end
      end
   end

   // ----------------------------
   // Program counter and fetch
   // ----------------------------
   // Taken branch loads target and turns the next cycle into a flush
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         pc_q <= `ABX_RST_PROG;
         ir_q <= 16'h0000;
         flush_q <= 1'b1;
         taken_q <= 1'b0;
      end else if (q4) begin
         if (take_q) begin
            pc_q <= br_tgt;
            flush_q <= 1'b1;
            taken_q <= 1'b1;
         end else begin
            ir_q <= PROG_DATA;
            pc_q <= pc_q + `ABX_PROG_STEP;
            flush_q <= 1'b0;
            taken_q <= 1'b0;
         end
      end else if (wr_fire && aw_addr_q == `ABX_ADR_PROG) begin
         if (w_strb_q[0]) begin
            pc_q[7:0] <= w_data_q[7:0];
         end
         if (w_strb_q[1]) begin
            pc_q[15:8] <= w_data_q[15:8];
         end
         if (w_strb_q[2]) begin
            pc_q[20:16] <= w_data_q[20:16];
         end
         flush_q <= 1'b1;
      end
   end

   // ----------------------------
   // Outputs
   // ----------------------------
   assign S_AXI_AWREADY = awready_q;
   assign S_AXI_WREADY = wready_q;
   assign S_AXI_BVALID = bvalid_q;
   assign S_AXI_BRESP = bresp_q;
   assign S_AXI_ARREADY = arready_q;
   assign S_AXI_RVALID = rvalid_q;
   assign S_AXI_RRESP = rresp_q;
   assign S_AXI_RDATA = rdata_q;
   assign PROG_ADDR = pc_q;
   assign DATA_ADDR = dm_addr_q;
   assign DATA_WDATA = res_q;
   assign DATA_WE = dm_we_q;

endmodule // abx_core

// ---- verification/abx_core_props.sv ----
/*
 Concurrent checks on the top ports of the instruction slice.
 Assumes one clock, an async active-low reset, binding onto abx_core.
*/
`include "abx_map.svh"

module abx_core_props (
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic [`ABX_PROG_W-1:0] PROG_ADDR,
   input wire logic [`ABX_DATA_AW-1:0] DATA_ADDR,
   input wire logic [7:0] DATA_WDATA,
   input wire logic DATA_WE,
   input wire logic [7:0] DATA_RDATA
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_N);

   logic [`ABX_PROG_W-1:0] prog_prev_q;
   logic [`ABX_PROG_W-1:0] step;

   // Counter one clock back
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         prog_prev_q <= '0;
      end else begin
         prog_prev_q <= PROG_ADDR;
      end
   end
   assign step = PROG_ADDR - prog_prev_q;

   // ------
   // Sequences
   // ------
   // Counter moved by the core, not by a register write
   sequence core_moved;
      $changed(PROG_ADDR) && !S_AXI_BVALID;
   endsequence
   // Write strobe of one cycle
   sequence write_pulse;
      DATA_WE ##1 !DATA_WE;
   endsequence

   // ------
   // Assertions
   // ------
   we_pulse_a: assert property (DATA_WE |-> write_pulse)
      else $error("data write strobe longer than one cycle");
   addr_held_a: assert property (DATA_WE |-> DATA_ADDR == $past(DATA_ADDR, 2))
      else $error("data address moved between read and write");
   wdata_subset_a: assert property (DATA_WE |-> (DATA_WDATA & ~DATA_RDATA) == 8'h00)
      else $error("written byte sets a bit absent from the read byte");
   branch_reach_a: assert property (core_moved |-> !step[0] && (step <= 21'h0000FE || step >= 21'h1FFF00))
      else $error("counter moved outside the relative reach");
   prog_step_a: assert property (DATA_WE && !S_AXI_BVALID && !$past(S_AXI_BVALID) |=> step == `ABX_PROG_STEP)
      else $error("counter not advanced by one word after a write");
   prog_spacing_a: assert property (core_moved |=> ($stable(PROG_ADDR) || S_AXI_BVALID)[*3])
      else $error("counter moved within one instruction cycle");
   bvalid_drop_a: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
      else $error("write response repeated");
   rvalid_drop_a: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
      else $error("read response repeated");
endmodule // abx_core_props

bind abx_core abx_core_props u_abx_core_props (.*);

// ---- verification/abx_mem_model.sv ----
/*
 Program memory and data register file beside the instruction slice.
 Assumes combinational reads; a data write lands at the edge ending a strobe cycle.
*/
`include "abx_map.svh"

module abx_mem_model (
   input wire logic CLOCK,
   input wire logic [`ABX_PROG_W-1:0] PROG_ADDR,
   output logic [15:0] PROG_DATA,
   input wire logic [`ABX_DATA_AW-1:0] DATA_ADDR,
   input wire logic [7:0] DATA_WDATA,
   input wire logic DATA_WE,
   output logic [7:0] DATA_RDATA
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [15:0] prog_mem [0:1023];
   logic [7:0] data_mem [0:4095];

   // Combinational reads
   assign PROG_DATA = prog_mem[PROG_ADDR[10:1]];
   assign DATA_RDATA = data_mem[DATA_ADDR];

   // Write at the end of the strobe cycle
   always @(posedge CLOCK) begin
      if (DATA_WE) begin
         data_mem[DATA_ADDR] <= DATA_WDATA;
      end
   end
endmodule // abx_mem_model

// ---- verification/and_bitclear_branch_exec_bench.sv ----
/*
 Self-checking bench: random and corner programs, results read back.
 Assumes the design, map header, checker and memory model compile first.
*/
`include "abx_map.svh"

module and_bitclear_branch_exec_bench;
   timeunit 1ns;
   timeprecision 1ps;

   logic CLOCK, RST_N, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
   logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY, DATA_WE;
   logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR, DATA_WDATA, DATA_RDATA, w, fv, f, res;
   logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rdv;
   logic [1:0] S_AXI_BRESP, S_AXI_RRESP, resp;
   logic [3:0] S_AXI_WSTRB, bank;
   logic [`ABX_PROG_W-1:0] PROG_ADDR;
   logic [15:0] PROG_DATA, loopw;
   logic [`ABX_DATA_AW-1:0] DATA_ADDR, da;
   logic [4:0] fl, efl;
   logic [2:0] bitsel;
   logic a, d, take;
   int checked, mismatches, i, k, n, t;

   abx_core u_abx_core (.*);
   abx_mem_model u_abx_mem_model (.*);

   // Clock
   initial begin
      CLOCK = 1'b0;
      forever #2.5 CLOCK = ~CLOCK;
   end

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic axi_wr(input logic [7:0] adr, input logic [31:0] dat);
      @(posedge CLOCK);
      S_AXI_AWADDR <= adr;
      S_AXI_WDATA <= dat;
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      S_AXI_BREADY <= 1'b1;
      // Only the watchdog ends a wait for the answer
      do begin
         @(posedge CLOCK);
         if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
         if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      end while (S_AXI_BVALID !== 1'b1);
      S_AXI_BREADY <= 1'b0;
      resp = S_AXI_BRESP;
   endtask

   task automatic axi_rd(input logic [7:0] adr);
      @(posedge CLOCK);
      S_AXI_ARADDR <= adr;
      S_AXI_ARVALID <= 1'b1;
      S_AXI_RREADY <= 1'b1;
      do begin
         @(posedge CLOCK);
         if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      end while (S_AXI_RVALID !== 1'b1);
      S_AXI_RREADY <= 1'b0;
      rdv = S_AXI_RDATA;
      resp = S_AXI_RRESP;
   endtask

   // Data address from access bit, address byte and bank
   function automatic logic [11:0] dadr(input logic acc, input logic [7:0] fa, input logic [3:0] bk);
      if (acc) return {bk, fa};
      return {(fa < `ABX_ACC_SPLIT) ? `ABX_ACC_LO_BANK : `ABX_ACC_HI_BANK, fa};
   endfunction

   task automatic do_reset;
      RST_N <= 1'b0;
      repeat (8) @(posedge CLOCK);
      RST_N <= 1'b1;
   endtask

   task automatic complete_run;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // Watchdog
   initial begin
      repeat (20000) @(posedge CLOCK);
      mismatches++;
      complete_run;
   end

   // ------
   // Tests
   // ------
   initial begin
      {RST_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
      {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
      S_AXI_WSTRB = 4'hF;
      void'($urandom(32'h9AE1BAEB));
      do_reset;
      // Reset values, then refused addresses
      for (i = 1; i < 5; i++) begin
         axi_rd(8'(4 * i));
         chk("reset value", rdv, 32'h0);
         chk("read resp", {30'h0, resp}, {30'h0, `ABX_RESP_OKAY});
      end
      axi_rd(8'h18);
      chk("unmapped read", {rdv[29:0], resp}, {30'h0, `ABX_RESP_SLVERR});
      axi_wr(8'h1C, 32'hFFFFFFFF);
      chk("unmapped write", {30'h0, resp}, {30'h0, `ABX_RESP_SLVERR});
      $display("test registers done");
      // Programs: and, bit clear, three branches with edge offsets first
      for (i = 0; i < 40; i++) begin
         k = i % 5;
         {w, fv, f, bank, bitsel, a, d} = 33'({$urandom, $urandom});
         fl = 5'($urandom);
         fl[`ABX_FLG_C] = 1'((i / 5) % 2);
         fl[`ABX_FLG_N] = fl[`ABX_FLG_C];
         n = (i < 5) ? -128 : (i < 10) ? 127 : int'($signed(8'($urandom)));
         if (n >= -2 && n <= 1) n = 127;
         take = (k == 2) ? fl[`ABX_FLG_C] : (k == 3) ? fl[`ABX_FLG_N] : !fl[`ABX_FLG_C];
         loopw = fl[`ABX_FLG_C] ? 16'hE2FF : 16'hE3FF;
         da = dadr(a, f, bank);
         do_reset;
         for (t = 0; t < 1024; t++) u_abx_mem_model.prog_mem[t] = 16'h0000;
         u_abx_mem_model.data_mem[k < 2 ? da : 12'h010] = (k < 2) ? fv : 8'hFF;
         u_abx_mem_model.prog_mem[256] = (k == 0) ? {6'h05, d, a, f} : (k == 1) ? {4'h9, bitsel, a, f} :
            {(k == 2) ? 8'hE2 : (k == 3) ? 8'hE6 : 8'hE3, 8'(n)};
         u_abx_mem_model.prog_mem[257] = (k < 2) ? loopw : 16'h9010;
         u_abx_mem_model.prog_mem[258] = loopw;
         u_abx_mem_model.prog_mem[257 + n] = 16'h9210;
         u_abx_mem_model.prog_mem[258 + n] = loopw;
         axi_wr(`ABX_ADR_WREG, {24'h0, w});
         axi_wr(`ABX_ADR_FLAGS, {27'h0, fl});
         axi_wr(`ABX_ADR_BANK, {28'h0, bank});
         axi_wr(`ABX_ADR_PROG, 32'h00000200);
         axi_wr(`ABX_ADR_CTRL, 32'h00000001);
         repeat (60) @(posedge CLOCK);
         axi_wr(`ABX_ADR_CTRL, 32'h00000000);
         res = w & fv;
         efl = fl;
         if (k == 0) efl[`ABX_FLG_N] = res[7];
         if (k == 0) efl[`ABX_FLG_Z] = (res == 8'h00);
         axi_rd(`ABX_ADR_WREG);
         chk("work register", rdv, {24'h0, (k == 0 && !d) ? res : w});
         axi_rd(`ABX_ADR_FLAGS);
         chk("flags", rdv, {27'h0, efl});
         if (k < 2) begin
            chk("file register", {24'h0, u_abx_mem_model.data_mem[da]}, {24'h0, (k == 1) ? fv & ~(8'h01 << bitsel) : d ? res : fv});
         end else begin
            chk("branch marker", {24'h0, u_abx_mem_model.data_mem[12'h010]}, {24'h0, take ? 8'hFD : 8'hFE});
         end
         $display("test case %0d kind %0d done", i, k);
      end
      complete_run;
   end
endmodule // and_bitclear_branch_exec_bench
